/* File: hdl/d2bs_bank_state.sv */
/*
  Per-bank command legality tracker of a DDR2 device, with an AXI4-Lite
  register slave. Assumes command pins synchronous to clk and a master
  that keeps one write and one read under way at most.
*/
`timescale 1ns/1ps

// Function
// - Command decoded from select, strobes and clock enable at rising edge.
// - Bursts run on under nop; autoclose burst accepts nothing for its bank.
// - Command illegal for one bank may be legal for another bank.
// - Precharging bank idles after row precharge time; extra precharge is nop.
// - Activating bank active after row-to-column delay; commands meanwhile illegal.
// - Write recovery lasts write recovery time; only new write allowed.
// - Autoclose write recovery then internal precharge; all commands illegal.
// - Refresh returns idle after refresh cycle time; commands meanwhile illegal.
// - Mode write returns idle after mode cycle time; commands meanwhile illegal.
module d2bs_bank_state
  import d2bs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire d2bs_pins_type pins,
  output logic illegalCmd,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] minus_one(input logic [7:0] v);
    return (v == 8'h00) ? 8'h00 : 8'(v - 8'h01);
  endfunction

  function automatic logic legal_for(input d2bs_bank_state_type st, input logic [7:0] cnt,
                                     input d2bs_cmd_type c, input logic bl8);
    logic atEdge;
    atEdge = bl8 && (cnt == INTR_POINT);
    unique case (c)
      CMD_ACTIVATE: return st == BANK_IDLE;
      CMD_READ: return (st == BANK_ACTIVE) || ((st == BANK_READ) && atEdge);
      CMD_WRITE: return (st == BANK_ACTIVE) || (st == BANK_WRITE_RECOV) ||
                        ((st == BANK_WRITE) && atEdge);
      CMD_PRECHARGE: return (st == BANK_ACTIVE) || (st == BANK_IDLE) ||
                            (st == BANK_PRECHARGING);
      CMD_MODE, CMD_REFRESH, CMD_RESERVED, CMD_NOP: return 1'b1;
    endcase
  endfunction

  // ==========================================================
  // State
  d2bs_bank_state_type bankState [NUM_BANKS];
  logic [7:0] bankCnt [NUM_BANKS];
  logic [NUM_BANKS-1:0] bankOk;
  logic [NUM_BANKS-1:0] bankIdle;
  logic prevCke;
  logic burstLen8;
  logic [31:0] timing0;
  logic [31:0] timing1;
  logic illegalSticky;
  logic [15:0] illCount;
  logic next_illegal;
  logic accepted;
  logic allIdle;
  logic cmdValid;
  logic closeAll;
  d2bs_cmd_type cmd;
  logic [7:0] burstLoad;
  logic [7:0] awAddr;
  logic awGot;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wGot;
  logic [31:0] readWord;
  logic readMapped;
  logic writeMapped;

  // ==========================================================
  // Command decode
  // decode at edge
  assign cmdValid = prevCke && pins.clockEnable && !pins.chipSelectN;
  assign cmd = d2bs_cmd_type'({pins.rowStrobeN, pins.colStrobeN, pins.writeEnableN});
  assign closeAll = (cmd == CMD_PRECHARGE) && pins.addr[10];
  assign allIdle = &bankIdle;
  assign burstLoad = burstLen8 ? minus_one(BURST8_CYC) : minus_one(BURST4_CYC);

  // Clock enable of the previous edge
  always_ff @(posedge clk) begin
    if (reset) begin
      prevCke <= 1'b0;
    end else if (clkEn) begin
      prevCke <= pins.clockEnable;
    end
  end

  // Legality of the decoded command
  always_comb begin
    next_illegal = 1'b0;
    if (cmdValid) begin
      unique case (cmd)
        CMD_REFRESH, CMD_MODE: next_illegal = !allIdle;
        CMD_PRECHARGE: next_illegal = closeAll ? !(&bankOk) : !bankOk[pins.bank];
        CMD_ACTIVATE, CMD_READ, CMD_WRITE: next_illegal = !bankOk[pins.bank];
        CMD_RESERVED, CMD_NOP: next_illegal = 1'b0;
      endcase
    end
  end
  assign accepted = cmdValid && !next_illegal;

  // ==========================================================
  // Per-bank state machines
  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    logic targeted;
    assign bankOk[i] = legal_for(bankState[i], bankCnt[i], cmd, burstLen8);
    assign bankIdle[i] = bankState[i] == BANK_IDLE;
    assign targeted = (pins.bank == 2'(i)) || closeAll;

    always_ff @(posedge clk) begin
      if (reset) begin
        bankState[i] <= BANK_IDLE;
        bankCnt[i] <= 8'h00;
      end else if (clkEn) begin
        if (accepted && (cmd == CMD_REFRESH)) begin
          bankState[i] <= BANK_REFRESHING;
          bankCnt[i] <= minus_one(timing1[TIM_RC_LSB +: 8]);
        end else if (accepted && (cmd == CMD_MODE)) begin
          bankState[i] <= BANK_MODE_ACCESS;
          bankCnt[i] <= minus_one(timing0[TIM_MRD_LSB +: 8]);
        end else if (accepted && targeted && (cmd == CMD_ACTIVATE)) begin
          bankState[i] <= BANK_ACTIVATING;
          bankCnt[i] <= minus_one(timing0[TIM_RCD_LSB +: 8]);
        end else if (accepted && targeted && (cmd == CMD_READ)) begin
          bankState[i] <= pins.addr[10] ? BANK_READ_AP : BANK_READ;
          bankCnt[i] <= burstLoad;
        end else if (accepted && targeted && (cmd == CMD_WRITE)) begin
          bankState[i] <= pins.addr[10] ? BANK_WRITE_AP : BANK_WRITE;
          bankCnt[i] <= burstLoad;
        end else if (accepted && targeted && (cmd == CMD_PRECHARGE) &&
                     (bankState[i] == BANK_ACTIVE)) begin
          bankState[i] <= BANK_PRECHARGING;
          bankCnt[i] <= minus_one(timing0[TIM_RP_LSB +: 8]);
        end else if (!bankIdle[i] && (bankState[i] != BANK_ACTIVE)) begin
          if (bankCnt[i] != 8'h00) begin
            bankCnt[i] <= 8'(bankCnt[i] - 8'h01);
          end else begin
            unique case (bankState[i])
              BANK_READ, BANK_WRITE_RECOV, BANK_ACTIVATING: bankState[i] <= BANK_ACTIVE;
              BANK_WRITE: begin
                bankState[i] <= BANK_WRITE_RECOV;
                bankCnt[i] <= minus_one(timing0[TIM_WR_LSB +: 8]);
              end
              BANK_WRITE_AP: begin
                bankState[i] <= BANK_WRITE_RECOV_AP;
                bankCnt[i] <= minus_one(timing0[TIM_WR_LSB +: 8]);
              end
              BANK_READ_AP, BANK_WRITE_RECOV_AP: begin
                bankState[i] <= BANK_PRECHARGING;
                bankCnt[i] <= minus_one(timing0[TIM_RP_LSB +: 8]);
              end
              default: bankState[i] <= BANK_IDLE;
            endcase
          end
        end
      end
    end
  end

  // ==========================================================
  // Illegal command flag and tallies
  // flag illegal commands
  always_ff @(posedge clk) begin
    if (reset) begin
      illegalCmd <= 1'b0;
      illCount <= 16'h0000;
    end else if (clkEn) begin
      illegalCmd <= next_illegal;
      if (next_illegal) begin
        illCount <= 16'(illCount + 16'h0001);
      end
    end
  end

  // Sticky bit, set wins over write-one-clear
  always_ff @(posedge clk) begin
    if (reset) begin
      illegalSticky <= 1'b0;
    end else if (clkEn) begin
      if (next_illegal) begin
        illegalSticky <= 1'b1;
      end else if (awGot && wGot && !s_axi_bvalid && (awAddr == REG_STATUS) &&
                   wStrb[STAT_STICKY_BIT / 8] && wData[STAT_STICKY_BIT]) begin
        illegalSticky <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  assign writeMapped = (awAddr == REG_CTRL) || (awAddr == REG_TIMING0) ||
                       (awAddr == REG_TIMING1) || (awAddr == REG_STATUS);

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awGot <= 1'b0;
      wGot <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr[7:0];
        awGot <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wGot <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awGot && wGot && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awGot <= 1'b0;
        wGot <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control and timing registers, byte lanes honoured
  always_ff @(posedge clk) begin
    if (reset) begin
      burstLen8 <= 1'b0;
      timing0 <= TIMING0_RESET;
      timing1 <= TIMING1_RESET;
    end else if (clkEn && awGot && wGot && !s_axi_bvalid) begin
      for (int b = 0; b < 4; b++) begin
        if (wStrb[b] && (awAddr == REG_TIMING0)) begin
          timing0[b*8 +: 8] <= wData[b*8 +: 8];
        end
        if (wStrb[b] && (awAddr == REG_TIMING1)) begin
          timing1[b*8 +: 8] <= wData[b*8 +: 8];
        end
      end
      if (wStrb[0] && (awAddr == REG_CTRL)) begin
        burstLen8 <= wData[CTRL_BL8_BIT];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_comb begin
    readMapped = 1'b1;
    unique case (s_axi_araddr[7:0])
      REG_CTRL: readWord = {31'h00000000, burstLen8};
      REG_TIMING0: readWord = timing0;
      REG_TIMING1: readWord = timing1;
      REG_STATUS: readWord = {14'h0000, allIdle, illegalSticky, bankState[3], bankState[2],
                              bankState[1], bankState[0]};
      REG_ILLCOUNT: readWord = {16'h0000, illCount};
      default: begin
        readWord = 32'h00000000;
        readMapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= readWord;
        s_axi_rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Assertions on bank 0, one also on bank 1
  property p_autoclose_locked;
    @(posedge clk) disable iff (reset)
      clkEn && cmdValid && (pins.bank == 2'h0) && (cmd != CMD_NOP) && (cmd != CMD_RESERVED) &&
      ((bankState[0] == BANK_READ_AP) || (bankState[0] == BANK_WRITE_AP)) |=> illegalCmd;
  endproperty
  a_autoclose_locked: assert property (p_autoclose_locked) else $error("autoclose accepted");

  property p_other_bank;
    @(posedge clk) disable iff (reset)
      clkEn && cmdValid && (cmd == CMD_ACTIVATE) && (pins.bank == 2'h1) &&
      (bankState[0] == BANK_ACTIVE) && (bankState[1] == BANK_IDLE)
      |=> !illegalCmd && (bankState[1] == BANK_ACTIVATING);
  endproperty
  a_other_bank: assert property (p_other_bank) else $error("other bank refused");

  property p_pre_nop;
    @(posedge clk) disable iff (reset)
      clkEn && cmdValid && (cmd == CMD_PRECHARGE) && !pins.addr[10] && (pins.bank == 2'h0) &&
      (bankState[0] == BANK_PRECHARGING) && (bankCnt[0] != 8'h00)
      |=> !illegalCmd && (bankState[0] == BANK_PRECHARGING);
  endproperty
  a_pre_nop: assert property (p_pre_nop) else $error("precharge not nop");

  property p_activate_end;
    @(posedge clk) disable iff (reset)
      clkEn && (bankState[0] == BANK_ACTIVATING) && (bankCnt[0] == 8'h00)
      |=> bankState[0] == BANK_ACTIVE;
  endproperty
  a_activate_end: assert property (p_activate_end) else $error("activate not ended");

  property p_recov_read;
    @(posedge clk) disable iff (reset)
      clkEn && cmdValid && (cmd == CMD_READ) && (pins.bank == 2'h0) &&
      (bankState[0] == BANK_WRITE_RECOV) |=> illegalCmd && !$stable(illCount);
  endproperty
  a_recov_read: assert property (p_recov_read) else $error("read in recovery");

  property p_recov_ap;
    @(posedge clk) disable iff (reset)
      clkEn && (bankState[0] == BANK_WRITE_RECOV_AP) && (bankCnt[0] == 8'h00)
      |=> bankState[0] == BANK_PRECHARGING;
  endproperty
  a_recov_ap: assert property (p_recov_ap) else $error("no internal precharge");

  property p_refresh_busy;
    @(posedge clk) disable iff (reset)
      clkEn && cmdValid && (cmd != CMD_NOP) && (cmd != CMD_RESERVED) &&
      ((bankState[0] == BANK_REFRESHING) || (bankState[0] == BANK_MODE_ACCESS)) |=> illegalCmd;
  endproperty
  a_refresh_busy: assert property (p_refresh_busy) else $error("busy accepted");

  property p_mode_end;
    @(posedge clk) disable iff (reset)
      clkEn && (bankState[0] == BANK_MODE_ACCESS) && (bankCnt[0] == 8'h00)
      |=> bankState[0] == BANK_IDLE;
  endproperty
  a_mode_end: assert property (p_mode_end) else $error("mode not ended");

  property p_illegal_hold;
    @(posedge clk) disable iff (reset)
      clkEn && cmdValid && (cmd == CMD_ACTIVATE) && (pins.bank == 2'h0) &&
      (bankState[0] == BANK_ACTIVE) |=> illegalCmd && (bankState[0] == BANK_ACTIVE);
  endproperty
  a_illegal_hold: assert property (p_illegal_hold) else $error("illegal changed bank");

endmodule

/* File: hdl/d2bs_pkg.sv */
/*
  Shared constants, types and the register map of the DDR2 bank-state
  checker. Assumes a 40 MHz system clock and a 32-bit AXI4-Lite master.
*/
package d2bs_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int T_RCD_NS = 15;
  localparam int T_RP_NS = 15;
  localparam int T_WR_NS = 15;
  localparam int T_RC_NS = 60;
  localparam int T_MRD_NS = 50;
  // Least times round up to whole cycles
  localparam logic [7:0] RCD_CYC = 8'((T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] WR_CYC = 8'((T_WR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RC_CYC = 8'((T_RC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] MRD_CYC = 8'((T_MRD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Burst lengths 4 and 8 take 2 and 4 clocks; count value at 4-beat edge
  localparam logic [7:0] BURST4_CYC = 8'h02;
  localparam logic [7:0] BURST8_CYC = 8'h04;
  // Two clocks after the burst began, counter seen as 2
  localparam logic [7:0] INTR_POINT = 8'h02;
  localparam int NUM_BANKS = 4;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMING0 = 8'h04;
  localparam logic [7:0] REG_TIMING1 = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_ILLCOUNT = 8'h10;
  localparam int CTRL_BL8_BIT = 0;
  localparam int TIM_RCD_LSB = 0;
  localparam int TIM_RP_LSB = 8;
  localparam int TIM_WR_LSB = 16;
  localparam int TIM_MRD_LSB = 24;
  localparam int TIM_RC_LSB = 0;
  localparam int STAT_STICKY_BIT = 16;
  localparam logic [31:0] TIMING0_RESET = {MRD_CYC, WR_CYC, RP_CYC, RCD_CYC};
  localparam logic [31:0] TIMING1_RESET = {24'h000000, RC_CYC};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    BANK_IDLE = 4'b0000,
    BANK_ACTIVATING = 4'b0001,
    BANK_ACTIVE = 4'b0010,
    BANK_READ = 4'b0011,
    BANK_WRITE = 4'b0100,
    BANK_READ_AP = 4'b0101,
    BANK_WRITE_AP = 4'b0110,
    BANK_WRITE_RECOV = 4'b0111,
    BANK_WRITE_RECOV_AP = 4'b1000,
    BANK_PRECHARGING = 4'b1001,
    BANK_REFRESHING = 4'b1010,
    BANK_MODE_ACCESS = 4'b1011
  } d2bs_bank_state_type;

  // Row, column and write strobes, active low, in that order
  typedef enum logic [2:0] {
    CMD_MODE = 3'b000,
    CMD_REFRESH = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVATE = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ = 3'b101,
    CMD_RESERVED = 3'b110,
    CMD_NOP = 3'b111
  } d2bs_cmd_type;

  typedef struct packed {
    logic clockEnable;
    logic chipSelectN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeEnableN;
    logic [1:0] bank;
    logic [13:0] addr;
    logic termEnable;
  } d2bs_pins_type;

endpackage

/* File: verif/d2bs_ctrl_model.sv */
/*
  Behavioural memory controller driving the command pins of the bank-state tracker.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps

module d2bs_ctrl_model
  import d2bs_pkg::*;
(
  input wire logic clk,
  output d2bs_pins_type pins
);
  // ==========================================================
  // Pin levels
  logic cke = 1'h0;

  initial begin
    pins = '0;
    pins.chipSelectN = 1'h1;
    pins.rowStrobeN = 1'h1;
    pins.colStrobeN = 1'h1;
    pins.writeEnableN = 1'h1;
  end

  task automatic drive(input d2bs_cmd_type c, input logic [1:0] b, input logic [13:0] a,
                       input logic sel);
    d2bs_pins_type p;
    p.clockEnable = cke;
    p.chipSelectN = ~sel;
    {p.rowStrobeN, p.colStrobeN, p.writeEnableN} = c;
    p.bank = b;
    p.addr = a;
    p.termEnable = 1'h0;
    @(posedge clk);
    pins <= p;
    // Deselect after one edge so no command is sampled twice
    @(posedge clk);
    pins.chipSelectN <= 1'h1;
  endtask

  task automatic powerUp();
    cke = 1'h0;
    repeat (8000) @(posedge clk);
    cke = 1'h1;
    repeat (16) drive(CMD_NOP, 2'h0, 14'h0, 1'h1);
  endtask
endmodule

/* File: verif/d2bs_bank_state_tb.sv */
/*
  Self-checking bench of the bank-state tracker with a reference model.
  Assumes the controller model drives the pins and the bench is the bus master.
*/
`timescale 1ns/1ps

module d2bs_bank_state_tb
  import d2bs_pkg::*;
;
  // ==========================================================
  // Signals and model state
  localparam int SETTLE = 20;
  localparam int LIMIT = 20000;
  localparam d2bs_cmd_type IC [11] = '{CMD_PRECHARGE, CMD_MODE, CMD_MODE, CMD_MODE, CMD_MODE,
    CMD_PRECHARGE, CMD_REFRESH, CMD_REFRESH, CMD_MODE, CMD_MODE, CMD_MODE};
  localparam logic [1:0] IB [11] = '{0, 2, 3, 1, 0, 0, 0, 0, 0, 1, 1};
  localparam logic [13:0] IA [11] = '{14'h0400, 14'h0, 14'h0, 14'h0, 14'h0100, 14'h0400,
    14'h0, 14'h0, 14'h0002, 14'h0380, 14'h0};
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic clkEn = 1'h1;
  d2bs_pins_type pins;
  logic illegalCmd, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic rready = 1'h0, awready, wready, bvalid, arready, rvalid, sticky = 1'h0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic [1:0] bresp, rresp, r;
  int failures = 0, cmpCount = 0, cycles = 0, seed = 75290, illCount = 0;
  d2bs_bank_state_type st [NUM_BANKS] = '{default: BANK_IDLE};
  logic bl8 = 1'h0;
  logic [4:0] last = 5'h1f;

  always #12.5 clk = ~clk;

  d2bs_ctrl_model i_ctrl (.clk(clk), .pins(pins));
  d2bs_bank_state i_dut (.clk(clk), .reset(reset), .clkEn(clkEn), .pins(pins),
    .illegalCmd(illegalCmd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog on run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      test_done();
    end
  end

  // ==========================================================
  // Bus master
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic got;
    got = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!got) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      got = bvalid;
    end
    rs = bresp;
    bready <= 1'h0;
  endtask

  task automatic axiRead(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic got;
    got = 1'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!got) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      got = rvalid;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  // ==========================================================
  // Reference model of bank legality
  function automatic logic legalOf(d2bs_cmd_type c, logic [1:0] b, logic a10);
    logic idle;
    logic pre;
    idle = 1'h1;
    pre = 1'h1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      idle &= (st[i] == BANK_IDLE);
      pre &= (st[i] inside {BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING});
    end
    case (c)
      CMD_NOP: return 1'h1;
      CMD_ACTIVATE: return st[b] == BANK_IDLE;
      CMD_READ: return st[b] == BANK_ACTIVE ||
        (bl8 && st[b] == BANK_READ && last == {CMD_READ, b});
      CMD_WRITE: return st[b] inside {BANK_ACTIVE, BANK_WRITE_RECOV} ||
        (bl8 && st[b] == BANK_WRITE && last == {CMD_WRITE, b});
      CMD_PRECHARGE: return a10 ? pre : st[b] inside {BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING};
      CMD_REFRESH, CMD_MODE: return idle;
      default: return 1'h0;
    endcase
  endfunction

  function automatic void apply(d2bs_cmd_type c, logic [1:0] b, logic a10);
    for (int i = 0; i < NUM_BANKS; i++) begin
      case (c)
        CMD_ACTIVATE: if (i == b) st[i] = BANK_ACTIVATING;
        CMD_READ: if (i == b) st[i] = a10 ? BANK_READ_AP : BANK_READ;
        CMD_WRITE: if (i == b) st[i] = a10 ? BANK_WRITE_AP : BANK_WRITE;
        CMD_PRECHARGE: if ((a10 || i == b) && st[i] != BANK_IDLE) st[i] = BANK_PRECHARGING;
        CMD_REFRESH: st[i] = BANK_REFRESHING;
        CMD_MODE: st[i] = BANK_MODE_ACCESS;
        default: ;
      endcase
    end
  endfunction

  // Short waits end write bursts; long waits end every timed state
  function automatic void age(logic full);
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (st[i] == BANK_WRITE) st[i] = BANK_WRITE_RECOV;
      if (st[i] == BANK_WRITE_AP) st[i] = BANK_WRITE_RECOV_AP;
      if (full && st[i] inside {BANK_ACTIVATING, BANK_READ, BANK_WRITE_RECOV}) st[i] = BANK_ACTIVE;
      if (full && st[i] != BANK_ACTIVE) st[i] = BANK_IDLE;
    end
  endfunction

  function automatic logic [13:0] ra(logic a10);
    logic [13:0] v;
    v = 14'($random(seed));
    v[10] = a10;
    return v;
  endfunction

  // ==========================================================
  // Command issue and result comparison
  task automatic cmd(d2bs_cmd_type c, logic [1:0] b, logic [13:0] a, logic sel = 1'h1);
    logic ok;
    ok = !sel || legalOf(c, b, a[10]);
    i_ctrl.drive(c, b, a, sel);
    @(negedge clk);
    check(32'(illegalCmd), 32'(!ok));
    if (!ok) begin
      illCount++;
      sticky = 1'h1;
    end else if (sel) begin
      apply(c, b, a[10]);
    end
    last = (ok && sel) ? {c, b} : 5'h1f;
  endtask

  task automatic nops(int n);
    logic s;
    repeat (n) begin
      s = 1'($random(seed));
      cmd(s ? CMD_NOP : d2bs_cmd_type'(3'($random(seed))), 2'($random(seed)), ra(1'h0), s);
    end
    age(n >= SETTLE);
  endtask

  task automatic checkStatus();
    logic idle;
    idle = 1'h1;
    axiRead(32'(REG_STATUS), d, r);
    for (int i = 0; i < NUM_BANKS; i++) begin
      check(32'(d[4*i +: 4]), 32'(st[i]));
      idle &= (st[i] == BANK_IDLE);
    end
    check(32'(d[17:16]), 32'({idle, sticky}));
    axiRead(32'(REG_ILLCOUNT), d, r);
    check(32'(d[15:0]), 32'(illCount[15:0]));
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    axiRead(32'(REG_TIMING0), d, r);
    check(d, TIMING0_RESET);
    axiRead(32'(REG_TIMING1), d, r);
    check(d, TIMING1_RESET);
    axiRead(32'h40, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    axiWrite(32'(REG_ILLCOUNT), 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR));
    $display("test registers ended");
    i_ctrl.powerUp();
    for (int i = 0; i < 11; i++) begin
      cmd(IC[i], IB[i], IA[i]);
      nops(i == 8 ? 200 : SETTLE);
    end
    checkStatus();
    axiWrite(32'(REG_TIMING0), 32'h04080404, r);
    axiWrite(32'(REG_TIMING1), 32'h00000006, r);
    check(32'(r), 32'(RESP_OKAY));
    $display("test init ended");
    cmd(CMD_ACTIVATE, 2'h0, ra(1'h0));
    cmd(CMD_READ, 2'h0, ra(1'h0));
    cmd(CMD_REFRESH, 2'h0, ra(1'h0));
    cmd(CMD_ACTIVATE, 2'h1, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_READ, 2'h0, ra(1'h0));
    cmd(CMD_WRITE, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_READ, 2'h0, ra(1'h0));
    cmd(CMD_READ, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_READ, 2'h1, ra(1'h1));
    cmd(CMD_READ, 2'h1, ra(1'h1));
    nops(SETTLE);
    checkStatus();
    $display("test activate and burst ended");
    cmd(CMD_ACTIVATE, 2'h0, ra(1'h0));
    cmd(CMD_WRITE, 2'h0, ra(1'h0));
    nops(3);
    cmd(CMD_READ, 2'h0, ra(1'h0));
    cmd(CMD_WRITE, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_WRITE, 2'h0, ra(1'h1));
    cmd(CMD_READ, 2'h0, ra(1'h0));
    nops(2);
    cmd(CMD_PRECHARGE, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_ACTIVATE, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_PRECHARGE, 2'h0, ra(1'h0));
    cmd(CMD_PRECHARGE, 2'h0, ra(1'h0));
    cmd(CMD_READ, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_REFRESH, 2'h0, ra(1'h0));
    cmd(CMD_ACTIVATE, 2'h3, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_MODE, 2'h0, 14'h0002);
    cmd(CMD_ACTIVATE, 2'h3, ra(1'h0));
    nops(SETTLE);
    // Burst length 8: same-type interrupt at the 4-beat edge
    axiWrite(32'(REG_CTRL), 32'h1, r);
    bl8 = 1'h1;
    check(32'(r), 32'(RESP_OKAY));
    axiRead(32'(REG_CTRL), d, r);
    check(d, 32'h1);
    cmd(CMD_ACTIVATE, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_READ, 2'h0, ra(1'h0));
    cmd(CMD_READ, 2'h0, ra(1'h0));
    cmd(CMD_WRITE, 2'h0, ra(1'h0));
    nops(SETTLE);
    cmd(CMD_WRITE, 2'h0, ra(1'h0));
    cmd(CMD_WRITE, 2'h0, ra(1'h0));
    nops(SETTLE);
    checkStatus();
    axiWrite(32'(REG_STATUS), 32'h00010000, r);
    sticky = 1'h0;
    checkStatus();
    // Clock enable low freezes the tracker
    @(posedge clk);
    clkEn <= 1'h0;
    i_ctrl.drive(CMD_ACTIVATE, 2'h1, ra(1'h0), 1'h1);
    @(posedge clk);
    clkEn <= 1'h1;
    checkStatus();
    $display("test recovery and refresh ended");
    test_done();
  end
endmodule
